// >>> inc/lpm_pkg.sv
// Power-mode manager shared types and constants.
// Assumes a single 125 MHz clock domain.
package lpm_pkg;

    // ****************************************
    // Modes and requests
    // ****************************************
    typedef enum logic [2:0] {
        LPM_ACTIVE,
        LPM_MODEM,
        LPM_LIGHT,
        LPM_DEEP,
        LPM_HIBER
    } lpm_mode_t;

    typedef struct packed {
        logic cpu_pwr;
        logic cpu_clk_en;
        logic radio_pwr;
        logic rtc_mem_pwr;
        logic rtc_per_pwr;
        logic coproc_run;
        logic osc8m_en;
        logic rtc_timer_en;
        logic gpio_hold;
    } lpm_dom_t;

    typedef struct packed {
        logic mac;
        logic host;
        logic rtc_timer;
        logic ext_int;
        logic rtc_gpio;
        logic coproc;
    } lpm_wake_t;

    localparam int  LPM_CLK_MHZ       = 125;
    localparam int  LPM_RESTORE_NS    = 1000;
    localparam int  LPM_RESTORE_CYC   =
        (LPM_RESTORE_NS * LPM_CLK_MHZ + 999) / 1000;
    localparam int  LPM_CNT_W         = 8;
    localparam int  LPM_DIV_W         = 3;
    localparam logic [LPM_DIV_W-1:0] LPM_DIV_FULL = 3'h0;
    localparam logic [LPM_DIV_W-1:0] LPM_DIV_MIN  = 3'h7;
    localparam int  LPM_DUTY_PERIOD   = 100;
    localparam int  LPM_DUTY_ON       = 1;
    localparam int  LPM_DUTY_W        = 7;
    localparam int  LPM_DUTY_PRE      = 1250;
    localparam int  LPM_PRE_W         = 11;
    localparam int  LPM_SENSE_W       = 12;

endpackage

// >>> core/lpm_duty.sv
// Sensor duty-cycle generator for sensor-monitored sleep.
// Assumes one clock; period tick comes from an internal prescaler.
`timescale 1ns/100ps
module lpm_duty
    import lpm_pkg::*;
#(
    parameter int PERIOD = LPM_DUTY_PERIOD,
    parameter int ON     = LPM_DUTY_ON,
    parameter int PRE    = LPM_DUTY_PRE
) (
    input  wire logic i_clk,    // System clock
    input  wire logic i_rstn,   // Async reset, active low
    input  wire logic i_en,     // Sensor monitoring enabled
    output logic      o_conv,   // Converter active window
    output logic      o_slot    // One-cycle pulse in the last cycle of the window
);

    logic [LPM_PRE_W-1:0]  pre_q;
    logic [LPM_DUTY_W-1:0] cnt_q;
    logic                  tick;

    assign tick = (pre_q == LPM_PRE_W'(PRE - 1));

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_q <= '0;
        end else if (!i_en || tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else if (!i_en) begin
            cnt_q <= '0;
        end else if (tick) begin
            if (cnt_q == LPM_DUTY_W'(PERIOD - 1)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // 1% duty: converter on for ON of PERIOD ticks
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conv <= 1'b0;
            o_slot <= 1'b0;
        end else begin
            o_conv <= i_en && (cnt_q < LPM_DUTY_W'(ON)); // R13
            o_slot <= i_en && tick && (cnt_q == '0);     // R13
        end
    end

endmodule

// >>> core/lpm_mgr.sv
// Power-mode manager: mode sequencing, domain controls, wake logic.
// Assumes wake and pin inputs are asynchronous; software requests
// and sensor data come from logic on i_clk.
`timescale 1ns/100ps

// Contract
// R1 - Active mode keeps radio powered
// R2 - Modem-sleep: CPU runs, radio and baseband off
// R3 - Light-sleep pauses CPU, RTC and coprocessor run
// R4 - Any wake event ends light-sleep; the coproc wake source is not decoded in light-sleep
// R5 - Deep-sleep powers only RTC memory and peripherals
// R6 - Connection state saved before deep-sleep
// R7 - Hibernation: oscillator, coprocessor, recovery memory off
// R8 - Hibernation keeps one RTC timer and GPIOs
// R9 - Hibernation exits only on timer or GPIO
// R10 - Wireless enabled: alternate active and modem-sleep
// R11 - Modem-sleep CPU clock follows load
// R12 - Deep-sleep coprocessor keeps GPIO, I2C usable
// R13 - Sensor mode: converter 1% duty
// R14 - Power-up pin low: everything off
// R15 - Coprocessor runs from RTC slow memory
// R16 - CPU wakes on external, timer, or both
// R17 - Coprocessor wakes CPU on voltage threshold
// R18 - GPIOs may hold state while sleeping
// R19 - Sleep on request; restore before CPU resumes
module lpm_mgr
    import lpm_pkg::*;
#(
    parameter int RESTORE_CYC = LPM_RESTORE_CYC
) (
    input  wire logic             i_clk,          // System clock
    input  wire logic             i_rstn,         // Async reset, active low
    input  wire logic             i_chip_power_up_pin, // Power-up pin
    input  wire logic             i_sleep_req,    // Sleep request pulse
    input  wire lpm_mode_t        i_sleep_mode,   // Requested sleep mode
    input  wire logic             i_wlan_en,      // Wireless LAN enabled
    input  wire logic             i_traffic,      // Air traffic pending
    input  wire logic [LPM_DIV_W-1:0] i_cpu_load, // CPU load level
    input  wire logic             i_per_busy,     // Peripherals in use
    input  wire logic             i_gpio_hold_en, // Hold GPIOs in sleep
    input  wire logic             i_sensor_en,    // Sensor monitoring on
    input  wire logic             i_state_saved,  // Connection state saved
    input  wire lpm_wake_t        i_wake,         // Async wake sources
    input  wire logic [1:0]       i_wake_combo,   // Timer/ext wake policy
    input  wire logic [LPM_SENSE_W-1:0] i_sense,  // Coprocessor voltage
    input  wire logic [LPM_SENSE_W-1:0] i_thresh, // Voltage threshold
    output lpm_mode_t             o_mode,         // Current mode
    output lpm_dom_t              o_dom,          // Domain controls
    output logic [LPM_DIV_W-1:0]  o_cpu_div,      // CPU clock divider
    output logic                  o_save_req,     // Ask to save state
    output logic                  o_conv_en,      // Converter enable
    output logic                  o_cpu_run,      // CPU may execute
    output logic                  o_woke          // Wake pulse
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    lpm_wake_t wk_m_q;
    lpm_wake_t wk_s_q;
    logic      pu_m_q;
    logic      pu_s_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wk_m_q <= '0;
            wk_s_q <= '0;
            pu_m_q <= 1'b0;
            pu_s_q <= 1'b0;
        end else begin
            wk_m_q <= i_wake;
            wk_s_q <= wk_m_q;
            pu_m_q <= i_chip_power_up_pin;
            pu_s_q <= pu_m_q;
        end
    end

    // ****************************************
    // Sensor duty and coprocessor trigger
    // ****************************************
    logic conv;
    logic sensor_on;
    logic thresh_hit;

    lpm_duty u_duty (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_en   (sensor_on),
        .o_conv (conv),
        .o_slot ()
    );

    // Threshold sampled only inside converter window
    assign thresh_hit = conv && (i_sense >= i_thresh);           // R17

    // ****************************************
    // Wake qualification
    // ****************************************
    typedef enum {
        ST_OFF,
        ST_ACTIVE,
        ST_MODEM,
        ST_SAVE,
        ST_LIGHT,
        ST_DEEP,
        ST_HIBER,
        ST_RESTORE
    } lpm_st_t;

    lpm_st_t state_q;
    lpm_st_t state_d;
    logic    wake_light;
    logic    wake_deep;
    logic    wake_hiber;
    logic    tmr_ext;

    // Policy 0: either; 1: timer; 2: external; 3: both together
    always_comb begin
        case (i_wake_combo)
            2'h0:    tmr_ext = wk_s_q.rtc_timer || wk_s_q.ext_int; // R16
            2'h1:    tmr_ext = wk_s_q.rtc_timer;                   // R16
            2'h2:    tmr_ext = wk_s_q.ext_int;                     // R16
            default: tmr_ext = wk_s_q.rtc_timer && wk_s_q.ext_int; // R16
        endcase
    end

    assign wake_light = wk_s_q.mac || wk_s_q.host ||
                        wk_s_q.rtc_timer || wk_s_q.ext_int ||
                        wk_s_q.rtc_gpio || thresh_hit;           // R4
    assign wake_deep  = tmr_ext || wk_s_q.rtc_gpio ||
                        wk_s_q.coproc || thresh_hit;             // R16
    // Only timer and retained GPIOs are alive in hibernation
    assign wake_hiber = wk_s_q.rtc_timer || wk_s_q.rtc_gpio;     // R9

    // ****************************************
    // Mode sequencer
    // ****************************************
    logic [LPM_CNT_W-1:0] rst_cnt_q;
    logic                 restore_done;
    // State the restore began from; power-up gives no wake pulse
    lpm_st_t              target_q;

    assign restore_done = (rst_cnt_q == LPM_CNT_W'(RESTORE_CYC - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                state_d = ST_RESTORE;
            end
            ST_ACTIVE: begin
                if (i_sleep_req) begin                           // R19
                    case (i_sleep_mode)
                        LPM_MODEM: state_d = ST_MODEM;
                        LPM_LIGHT: state_d = ST_LIGHT;
                        LPM_DEEP:  state_d = ST_SAVE;            // R6
                        LPM_HIBER: state_d = ST_HIBER;
                        default:   state_d = ST_ACTIVE;
                    endcase
                end else if (i_wlan_en && !i_traffic) begin
                    state_d = ST_MODEM;                          // R10
                end
            end
            ST_MODEM: begin
                if (i_wlan_en && i_traffic) begin
                    state_d = ST_ACTIVE;                         // R10
                end else if (!i_wlan_en && !i_sleep_req) begin
                    state_d = ST_ACTIVE;
                end else if (i_sleep_req &&
                             i_sleep_mode == LPM_LIGHT) begin
                    state_d = ST_LIGHT;                          // R19
                end else if (i_sleep_req &&
                             i_sleep_mode == LPM_DEEP) begin
                    state_d = ST_SAVE;                           // R6
                end else if (i_sleep_req &&
                             i_sleep_mode == LPM_HIBER) begin
                    state_d = ST_HIBER;
                end
            end
            ST_SAVE: begin
                if (i_state_saved) begin
                    state_d = ST_DEEP;                           // R6
                end
            end
            ST_LIGHT: begin
                if (wake_light) begin
                    state_d = ST_RESTORE;                        // R4
                end
            end
            ST_DEEP: begin
                if (wake_deep) begin
                    state_d = ST_RESTORE;                        // R16
                end
            end
            ST_HIBER: begin
                if (wake_hiber) begin
                    state_d = ST_RESTORE;                        // R9
                end
            end
            ST_RESTORE: begin
                if (restore_done) begin
                    state_d = ST_ACTIVE;                         // R19
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    // Pin low overrides everything, whatever the state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_OFF;
        end else if (!pu_s_q) begin
            state_q <= ST_OFF;                                   // R14
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_cnt_q <= '0;
        end else if (state_q != ST_RESTORE || restore_done) begin
            rst_cnt_q <= '0;
        end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;                       // R19
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            target_q <= ST_OFF;
        end else if (state_q != ST_RESTORE) begin
            target_q <= state_q;
        end
    end

    assign sensor_on = (state_q == ST_DEEP) && i_sensor_en;      // R13

    // ****************************************
    // CPU clock scaling in modem-sleep
    // ****************************************
    // Heavier load or busy peripherals keep a faster clock
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cpu_div <= LPM_DIV_FULL;
        end else if (state_q == ST_MODEM) begin
            if (i_per_busy) begin
                o_cpu_div <= LPM_DIV_FULL;                       // R11
            end else begin
                o_cpu_div <= LPM_DIV_MIN - i_cpu_load;           // R11
            end
        end else begin
            o_cpu_div <= LPM_DIV_FULL;
        end
    end

    // ****************************************
    // Domain controls
    // ****************************************
    lpm_dom_t dom_d;

    always_comb begin
        dom_d = '0;
        case (state_q)
            ST_ACTIVE, ST_RESTORE, ST_SAVE: begin
                dom_d = '1;                                      // R1
                dom_d.gpio_hold = 1'b0;
            end
            ST_MODEM: begin
                dom_d = '1;                                      // R2
                dom_d.radio_pwr = 1'b0;                          // R2
                dom_d.gpio_hold = 1'b0;
            end
            ST_LIGHT: begin
                dom_d = '1;
                dom_d.cpu_clk_en = 1'b0;                         // R3
                dom_d.radio_pwr  = 1'b0;
                dom_d.gpio_hold  = i_gpio_hold_en;               // R18
            end
            ST_DEEP: begin
                dom_d.rtc_mem_pwr  = 1'b1;                       // R5
                dom_d.rtc_per_pwr  = 1'b1;                       // R12
                dom_d.coproc_run   = 1'b1;                       // R15
                dom_d.osc8m_en     = 1'b1;
                dom_d.rtc_timer_en = 1'b1;
                dom_d.gpio_hold    = i_gpio_hold_en;             // R18
            end
            ST_HIBER: begin                                      // R7
                dom_d.rtc_timer_en = 1'b1;                       // R8
                dom_d.rtc_per_pwr  = 1'b1;                       // R8
                dom_d.gpio_hold    = i_gpio_hold_en;             // R18
            end
            default: dom_d = '0;                                 // R7
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dom <= '0;
        end else if (!pu_s_q) begin
            o_dom <= '0;                                         // R14
        end else begin
            o_dom <= dom_d;
        end
    end

    // ****************************************
    // Mode report and handshakes
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mode <= LPM_HIBER;
        end else begin
            case (state_q)
                ST_MODEM: o_mode <= LPM_MODEM;
                ST_LIGHT: o_mode <= LPM_LIGHT;
                ST_DEEP:  o_mode <= LPM_DEEP;
                ST_HIBER, ST_OFF: o_mode <= LPM_HIBER;
                default:  o_mode <= LPM_ACTIVE;
            endcase
        end
    end

    // CPU stays halted until restore finishes
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cpu_run  <= 1'b0;
            o_save_req <= 1'b0;
            o_conv_en  <= 1'b0;
            o_woke     <= 1'b0;
        end else begin
            o_cpu_run  <= pu_s_q && (state_q == ST_ACTIVE ||     // R14
                                     state_q == ST_MODEM);       // R19
            o_save_req <= (state_q == ST_SAVE);                  // R6
            o_conv_en  <= conv;                                  // R13
            o_woke     <= (state_q == ST_RESTORE) && restore_done &&
                          (target_q != ST_OFF);
        end
    end

endmodule

// >>> bench/lpm_mgr_asserts.sv
// Port checker for the power-mode manager.
// Assumes binding to lpm_mgr; one clock domain.
`timescale 1ns/100ps
module lpm_mgr_asserts
    import lpm_pkg::*;
#(
    parameter int RESTORE_CYC = LPM_RESTORE_CYC
) (
    input wire logic      i_clk,               // System clock
    input wire logic      i_rstn,              // Async reset, active low
    input wire logic      i_chip_power_up_pin, // Power-up pin
    input wire lpm_wake_t i_wake,              // Wake sources
    input wire lpm_mode_t o_mode,              // Current mode
    input wire lpm_dom_t  o_dom,               // Domain controls
    input wire logic      o_save_req,          // Save request
    input wire logic      o_cpu_run,           // CPU may execute
    input wire logic      o_woke               // Wake pulse
);
    // Sync, restore and output stages, with margin
    localparam int WAKE_MAX = RESTORE_CYC + 12;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ****************************************
    // Mode domains
    // ****************************************
    a_active_radio_on: assert property (
        o_mode == LPM_ACTIVE && o_cpu_run |-> o_dom.radio_pwr)
        else $error("radio off in active mode");
    a_modem_radio_off: assert property (
        o_mode == LPM_MODEM && o_cpu_run |->
        !o_dom.radio_pwr && o_dom.cpu_clk_en)
        else $error("modem-sleep domains wrong");
    a_light_pause: assert property (
        $changed(o_mode) && o_mode == LPM_LIGHT |-> !o_cpu_run
        && o_dom.rtc_mem_pwr && o_dom.rtc_per_pwr && o_dom.coproc_run)
        else $error("light-sleep domains wrong");
    a_deep_domains: assert property (
        $changed(o_mode) && o_mode == LPM_DEEP |-> !o_dom.cpu_pwr
        && !o_dom.radio_pwr && o_dom.rtc_mem_pwr && o_dom.coproc_run)
        else $error("deep-sleep domains wrong");
    a_hiber_off: assert property (
        $changed(o_mode) && o_mode == LPM_HIBER |-> !o_dom.osc8m_en
        && !o_dom.coproc_run && !o_dom.rtc_mem_pwr)
        else $error("hibernation left domains on");
    a_save_first: assert property (
        $changed(o_mode) && o_mode == LPM_DEEP |-> $past(o_save_req))
        else $error("deep-sleep without save");

    // ****************************************
    // Power pin and wake
    // ****************************************
    a_pin_power_off: assert property (
        !i_chip_power_up_pin [*4] |-> o_dom == '0 && !o_cpu_run)
        else $error("domains on with pin low");
    a_light_wake: assert property (
        $rose(i_wake.ext_int) && o_mode == LPM_LIGHT |->
        ##[1:WAKE_MAX] o_woke)
        else $error("no wake from light-sleep");
    a_resume_restored: assert property (
        $rose(o_cpu_run) |-> o_mode == LPM_ACTIVE
        && o_dom.cpu_pwr && o_dom.cpu_clk_en)
        else $error("cpu resumed before restore");
    a_woke_single: assert property (
        o_woke |=> !o_woke)
        else $error("wake pulse too long");

    c_deep_entry: cover property ($changed(o_mode) && o_mode == LPM_DEEP);
    c_hiber_entry: cover property ($changed(o_mode) && o_mode == LPM_HIBER);
    c_wake_seen: cover property (o_woke);
endmodule

bind lpm_mgr lpm_mgr_asserts #(
    .RESTORE_CYC(RESTORE_CYC)
) u_lpm_mgr_asserts (
    .i_clk              (i_clk),
    .i_rstn             (i_rstn),
    .i_chip_power_up_pin(i_chip_power_up_pin),
    .i_wake             (i_wake),
    .o_mode             (o_mode),
    .o_dom              (o_dom),
    .o_save_req         (o_save_req),
    .o_cpu_run          (o_cpu_run),
    .o_woke             (o_woke)
);

// >>> bench/testbench.sv
// Self-checking bench for the power-mode manager.
// Assumes lpm_mgr with a short restore count; full sensor window.
`timescale 1ns/100ps
module testbench
    import lpm_pkg::*;
;
    logic                   i_clk = 1'b0;
    logic                   i_rstn = 1'b0;
    logic                   i_chip_power_up_pin = 1'b1;
    logic                   i_sleep_req = 1'b0;
    lpm_mode_t              i_sleep_mode = LPM_LIGHT;
    logic                   i_wlan_en = 1'b0;
    logic                   i_traffic = 1'b0;
    logic [LPM_DIV_W-1:0]   i_cpu_load = 3'h7;
    logic                   i_per_busy = 1'b0;
    logic                   i_gpio_hold_en = 1'b0;
    logic                   i_state_saved = 1'b0;
    lpm_wake_t              i_wake = '0;
    logic [1:0]             i_wake_combo = 2'h0;
    logic                   i_sensor_en = 1'b0;
    logic [LPM_SENSE_W-1:0] i_sense = 12'h000;
    logic [LPM_SENSE_W-1:0] i_thresh = 12'h800;
    lpm_mode_t              o_mode;
    lpm_dom_t               o_dom;
    logic [LPM_DIV_W-1:0]   o_cpu_div;
    logic                   o_save_req;
    logic                   o_conv_en;
    logic                   o_cpu_run;
    logic                   o_woke;
    int                     error_cnt = 0;
    int                     samples_checked = 0;

    always #4 i_clk = ~i_clk;

    // Short restore keeps each wake to a few cycles
    lpm_mgr #(.RESTORE_CYC(4)) u_lpm_mgr (
        .i_clk(i_clk), .i_rstn(i_rstn),
        .i_chip_power_up_pin(i_chip_power_up_pin),
        .i_sleep_req(i_sleep_req), .i_sleep_mode(i_sleep_mode),
        .i_wlan_en(i_wlan_en), .i_traffic(i_traffic),
        .i_cpu_load(i_cpu_load), .i_per_busy(i_per_busy),
        .i_gpio_hold_en(i_gpio_hold_en), .i_sensor_en(i_sensor_en),
        .i_state_saved(i_state_saved), .i_wake(i_wake),
        .i_wake_combo(i_wake_combo), .i_sense(i_sense),
        .i_thresh(i_thresh), .o_mode(o_mode), .o_dom(o_dom),
        .o_cpu_div(o_cpu_div), .o_save_req(o_save_req),
        .o_conv_en(o_conv_en), .o_cpu_run(o_cpu_run), .o_woke(o_woke));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk_bit(input logic got, input logic exp,
                           input string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask

    task automatic chk_mode(input lpm_mode_t got, input lpm_mode_t exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t mode %0d not %0d", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wait_run(input logic exp);
        int n;
        n = 0;
        while (o_cpu_run !== exp && n < 400) begin
            tick(1);
            n++;
        end
        chk_bit(o_cpu_run, exp, "cpu run state");
    endtask

    task automatic sleep_to(input lpm_mode_t m);
        @(posedge i_clk);
        i_sleep_mode <= m;
        i_sleep_req <= 1'b1;
        @(posedge i_clk);
        i_sleep_req <= 1'b0;
        tick(3);
    endtask

    task automatic wake_by(input lpm_wake_t w);
        @(posedge i_clk);
        i_wake <= w;
        wait_run(1'b1);
        chk_mode(o_mode, LPM_ACTIVE);
        chk_bit(o_dom.radio_pwr, 1'b1, "radio after wake");
        @(posedge i_clk);
        i_wake <= '0;
    endtask

    task automatic stay_asleep(input lpm_wake_t w);
        @(posedge i_clk);
        i_wake <= w;
        tick(20);
        chk_bit(o_cpu_run, 1'b0, "woke on blocked source");
        @(posedge i_clk);
        i_wake <= '0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_light();
        for (int i = 0; i < 4; i++) begin
            sleep_to(LPM_LIGHT);
            chk_mode(o_mode, LPM_LIGHT);
            chk_bit(o_dom.cpu_clk_en, 1'b0, "light cpu clock");
            chk_bit(o_dom.coproc_run, 1'b1, "light coproc");
            wake_by(lpm_wake_t'(6'h20 >> i));
        end
    endtask

    task automatic t_modem();
        logic [LPM_DIV_W-1:0] d_busy;
        @(posedge i_clk);
        i_wlan_en <= 1'b1;
        tick(4);
        chk_mode(o_mode, LPM_MODEM);
        chk_bit(o_dom.radio_pwr, 1'b0, "modem radio");
        chk_bit(o_cpu_run, 1'b1, "modem cpu");
        d_busy = o_cpu_div;
        @(posedge i_clk);
        i_cpu_load <= 3'h0;
        tick(4);
        chk_bit(o_cpu_div > d_busy, 1'b1, "idle cpu not slower");
        @(posedge i_clk);
        i_per_busy <= 1'b1;
        tick(3);
        chk_bit(o_cpu_div == LPM_DIV_FULL, 1'b1, "busy cpu slowed");
        @(posedge i_clk);
        i_per_busy <= 1'b0;
        i_traffic <= 1'b1;
        i_cpu_load <= 3'h7;
        tick(4);
        chk_mode(o_mode, LPM_ACTIVE);
        @(posedge i_clk);
        i_wlan_en <= 1'b0;
        i_traffic <= 1'b0;
    endtask

    task automatic deep_entry();
        sleep_to(LPM_DEEP);
        chk_bit(o_save_req, 1'b1, "no save request");
        chk_bit(o_mode == LPM_DEEP, 1'b0, "deep before save");
        @(posedge i_clk);
        i_state_saved <= 1'b1;
        @(posedge i_clk);
        i_state_saved <= 1'b0;
    endtask

    task automatic t_deep(input logic [1:0] c, input lpm_wake_t no,
                          input lpm_wake_t yes);
        @(posedge i_clk);
        i_wake_combo <= c;
        i_gpio_hold_en <= 1'b1;
        deep_entry();
        tick(3);
        chk_mode(o_mode, LPM_DEEP);
        chk_bit(o_dom.cpu_pwr, 1'b0, "deep cpu power");
        chk_bit(o_dom.coproc_run, 1'b1, "deep coproc");
        chk_bit(o_dom.gpio_hold, 1'b1, "gpio hold");
        if (no != '0) begin
            stay_asleep(no);
        end
        wake_by(yes);
    endtask

    // Seven cycles of margin before the window edge, one cycle after it
    task automatic t_sensor();
        @(posedge i_clk);
        i_sensor_en <= 1'b1;
        deep_entry();
        tick(3);
        chk_bit(o_conv_en, 1'b1, "converter idle");
        tick(LPM_DUTY_PRE * LPM_DUTY_ON - 8);
        chk_bit(o_conv_en, 1'b1, "window too short");
        chk_bit(o_cpu_run, 1'b0, "woke below threshold");
        tick(8);
        chk_bit(o_conv_en, 1'b0, "window too long");
        wake_by(lpm_wake_t'(6'h01));
        @(posedge i_clk);
        i_sense <= 12'h800;
        deep_entry();
        wait_run(1'b1);
    endtask

    task automatic t_hiber();
        sleep_to(LPM_HIBER);
        chk_bit(o_dom.osc8m_en, 1'b0, "hiber oscillator");
        chk_bit(o_dom.rtc_mem_pwr, 1'b0, "hiber memory");
        chk_bit(o_dom.rtc_timer_en, 1'b1, "hiber timer");
        stay_asleep(lpm_wake_t'(6'h35));
        wake_by(lpm_wake_t'(6'h02));
    endtask

    task automatic t_pin_off();
        @(posedge i_clk);
        i_chip_power_up_pin <= 1'b0;
        tick(5);
        chk_bit(|o_dom, 1'b0, "domains on with pin low");
        chk_bit(o_cpu_run, 1'b0, "cpu on with pin low");
        @(posedge i_clk);
        i_chip_power_up_pin <= 1'b1;
        wait_run(1'b1);
        chk_mode(o_mode, LPM_ACTIVE);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Sensor window dominates; whole run near 1600 cycles
    initial begin
        repeat (10000) @(posedge i_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        tick(4);
        chk_mode(o_mode, LPM_HIBER);
        chk_bit(|o_dom, 1'b0, "domains on in reset");
        @(posedge i_clk);
        i_rstn <= 1'b1;
        wait_run(1'b1);
        chk_mode(o_mode, LPM_ACTIVE);
        t_light();
        t_modem();
        t_deep(2'h0, lpm_wake_t'(6'h00), lpm_wake_t'(6'h08));
        t_deep(2'h1, lpm_wake_t'(6'h04), lpm_wake_t'(6'h08));
        t_deep(2'h2, lpm_wake_t'(6'h08), lpm_wake_t'(6'h04));
        t_deep(2'h3, lpm_wake_t'(6'h04), lpm_wake_t'(6'h0c));
        t_sensor();
        t_hiber();
        t_pin_off();
        conclude();
    end
endmodule
